// ### adc_seq_pkg.sv
// Purpose: Shared constants for the converter sequencer control block
// Assumes: 8-bit register port, one clock domain
// Notes: Offsets are byte addresses on the register port
package adc_seq_pkg;

  // Register offsets
  localparam logic [7:0] PIN_CFG_OFS = 8'hAE;
  localparam logic [7:0] CTRL_OFS = 8'hB1;
  localparam logic [7:0] RES_HI_OFS = 8'hB2;
  localparam logic [7:0] CKS_LO_OFS = 8'hB3;

  // Control/status field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_EOC_BIT = 5;
  localparam int CTRL_GCH_BIT = 4;

  // Clock select field positions in the low-result register
  localparam int CKS1_BIT = 6;
  localparam int CKS0_BIT = 4;

  // Reset values
  localparam logic [2:0] CHS_RST = 3'h0;
  localparam logic [1:0] CKS_RST = 2'h0;
  localparam logic [4:0] PIN_CFG_RST = 5'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Converter clock dividers per clock select code
  localparam logic [4:0] DIV_CKS0 = 5'h10;
  localparam logic [4:0] DIV_CKS1 = 5'h08;
  localparam logic [4:0] DIV_CKS2 = 5'h01;
  localparam logic [4:0] DIV_CKS3 = 5'h02;

  // Sequence counts
  localparam int CH_COUNT = 5;
  localparam int RES_W = 12;
  localparam logic [3:0] LAST_STEP = 4'hF;
  localparam logic [3:0] SAMPLE_LAST_STEP = 4'h3;
  localparam logic [1:0] LAST_TICK = 2'h3;
  localparam logic [10:0] TICKS_PER_CONV = 11'h040;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_RESOLVE = 3'b100
  } conv_state_t;

endpackage

// ### adc_sequencer_control.sv
// Purpose: Register file and successive-step sequencer for a 12-bit converter
// Assumes: Comparator answer is valid during each resolve step
// Notes: Result registers are not reset
//
// Behaviour
// - Start needs channel chosen, global enable, start
// - Completion sets end flag, stores result
// - End flag low while busy; completion clears start
// - Sixteen steps of four converter clocks
// - Bit 7 powers converter up or down
// - Bit 4 connects or disconnects channels
// - Channel codes 0..4 select inputs 0..4
// - Clock select bits 6,4 choose divider
// - High byte bits 11..4, low nibble 3..0
// - Result read-only; low write changes clock select
// - Result bits uninitialised after reset
// - Straight unsigned binary result code
// - Config bit one isolates digital pin path
// - Config bit zero keeps pin dual use
// - At most one pin connected at once
// - Enable leaves pin direction and pull-up alone
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cmp_above,
  output logic [7:0] o_rdata,
  output logic o_converter_power,
  output logic [adc_seq_pkg::CH_COUNT-1:0] o_channel_connect,
  output logic [adc_seq_pkg::CH_COUNT-1:0] o_pin_analog_only,
  output logic o_sample,
  output logic [adc_seq_pkg::RES_W-1:0] o_trial_code
);

  function automatic logic [4:0] div_limit(input logic [1:0] cks);
    logic [4:0] lim;
    case (cks)
      2'h0: lim = adc_seq_pkg::DIV_CKS0;
      2'h1: lim = adc_seq_pkg::DIV_CKS1;
      2'h2: lim = adc_seq_pkg::DIV_CKS2;
      default: lim = adc_seq_pkg::DIV_CKS3;
    endcase
    return lim;
  endfunction

  function automatic logic [4:0] channel_onehot(input logic en, input logic gch,
                                                 input logic [2:0] chs);
    logic [4:0] oh;
    oh = 5'h00;
    if (en && gch && chs < 3'h5) begin
      oh[chs] = 1'b1;
    end
    return oh;
  endfunction

  logic en_reg, en_next, start_reg, start_next, eoc_reg, eoc_next, gch_reg, gch_next;
  logic [2:0] chs_reg, chs_next;
  logic [1:0] cks_reg, cks_next;
  logic [4:0] pin_cfg_reg, pin_cfg_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [4:0] conn_reg, conn_next;
  logic sample_reg, sample_next;
  adc_seq_pkg::conv_state_t state_reg, state_next;
  logic [3:0] step_reg, step_next;
  logic [1:0] tick_reg, tick_next;
  logic [4:0] div_cnt_reg, div_cnt_next, div_lim_reg, div_lim_next;
  logic [11:0] sar_reg, sar_next, result_reg, result_next;
  logic wr_ctrl, wr_lo, wr_pin, busy, start_ok, abort, tick, step_end, done;
  logic [3:0] bidx;

  assign wr_ctrl = i_wr && (i_addr == adc_seq_pkg::CTRL_OFS);
  assign wr_lo = i_wr && (i_addr == adc_seq_pkg::CKS_LO_OFS);
  assign wr_pin = i_wr && (i_addr == adc_seq_pkg::PIN_CFG_OFS);
  assign busy = (state_reg != adc_seq_pkg::ST_IDLE);
  // Start needs enable and global channel in the same write
  assign start_ok = wr_ctrl && !busy && i_wdata[adc_seq_pkg::CTRL_START_BIT]
                    && i_wdata[adc_seq_pkg::CTRL_EN_BIT]
                    && i_wdata[adc_seq_pkg::CTRL_GCH_BIT];
  // Clearing start, enable or global channel stops a running conversion
  assign abort = busy && wr_ctrl && !(i_wdata[adc_seq_pkg::CTRL_START_BIT]
                 && i_wdata[adc_seq_pkg::CTRL_EN_BIT] && i_wdata[adc_seq_pkg::CTRL_GCH_BIT]);
  assign tick = busy && (div_cnt_reg == div_lim_reg - 5'h01);
  assign step_end = tick && (tick_reg == adc_seq_pkg::LAST_TICK);
  assign done = (state_reg == adc_seq_pkg::ST_RESOLVE) && step_end
                && (step_reg == adc_seq_pkg::LAST_STEP) && !abort;
  assign bidx = adc_seq_pkg::LAST_STEP - step_reg;

  // Register file
  always_comb begin
    en_next = en_reg;
    gch_next = gch_reg;
    chs_next = chs_reg;
    start_next = start_reg;
    eoc_next = eoc_reg;
    cks_next = cks_reg;
    pin_cfg_next = pin_cfg_reg;
    if (wr_ctrl) begin
      en_next = i_wdata[adc_seq_pkg::CTRL_EN_BIT];
      gch_next = i_wdata[adc_seq_pkg::CTRL_GCH_BIT];
      chs_next = i_wdata[2:0];
    end
    if (done) begin
      eoc_next = 1'b1;
      start_next = 1'b0;
    end else if (start_ok) begin
      eoc_next = 1'b0;
      start_next = 1'b1;
    end else if (abort) begin
      start_next = 1'b0;
    end else if (wr_ctrl && !busy) begin
      start_next = 1'b0;
      // A refused start leaves the end flag alone
      if (!i_wdata[adc_seq_pkg::CTRL_START_BIT]) begin
        eoc_next = i_wdata[adc_seq_pkg::CTRL_EOC_BIT];
      end
    end
    if (wr_lo) begin
      cks_next = {i_wdata[adc_seq_pkg::CKS1_BIT], i_wdata[adc_seq_pkg::CKS0_BIT]};
    end
    if (wr_pin) begin
      pin_cfg_next = i_wdata[4:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_reg <= 1'b0;
      gch_reg <= 1'b0;
      chs_reg <= adc_seq_pkg::CHS_RST;
      start_reg <= 1'b0;
      eoc_reg <= 1'b0;
      cks_reg <= adc_seq_pkg::CKS_RST;
      pin_cfg_reg <= adc_seq_pkg::PIN_CFG_RST;
    end else begin
      en_reg <= en_next;
      gch_reg <= gch_next;
      chs_reg <= chs_next;
      start_reg <= start_next;
      eoc_reg <= eoc_next;
      cks_reg <= cks_next;
      pin_cfg_reg <= pin_cfg_next;
    end
  end

  // Sequencer: four sample steps, then twelve bit decisions MSB first
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    tick_next = tick_reg;
    div_cnt_next = div_cnt_reg;
    div_lim_next = div_lim_reg;
    sar_next = sar_reg;
    if (start_ok) begin
      state_next = adc_seq_pkg::ST_SAMPLE;
      step_next = 4'h0;
      tick_next = 2'h0;
      div_cnt_next = 5'h00;
      div_lim_next = div_limit(cks_reg);
      sar_next = 12'h000;
    end else if (abort) begin
      state_next = adc_seq_pkg::ST_IDLE;
    end else if (busy) begin
      div_cnt_next = tick ? 5'h00 : div_cnt_reg + 5'h01;
      if (tick) begin
        tick_next = tick_reg + 2'h1;
      end
      if (step_end) begin
        step_next = step_reg + 4'h1;
        case (state_reg)
          adc_seq_pkg::ST_SAMPLE: begin
            if (step_reg == adc_seq_pkg::SAMPLE_LAST_STEP) begin
              state_next = adc_seq_pkg::ST_RESOLVE;
              sar_next = adc_seq_pkg::SAR_FIRST_TRIAL;
            end
          end
          adc_seq_pkg::ST_RESOLVE: begin
            // Keep the trial bit when input is at or above the code
            sar_next[bidx] = i_cmp_above;
            if (step_reg == adc_seq_pkg::LAST_STEP) begin
              state_next = adc_seq_pkg::ST_IDLE;
            end else begin
              sar_next[bidx - 4'h1] = 1'b1;
            end
          end
          default: state_next = adc_seq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= adc_seq_pkg::ST_IDLE;
      step_reg <= 4'h0;
      tick_reg <= 2'h0;
      div_cnt_reg <= 5'h00;
      div_lim_reg <= adc_seq_pkg::DIV_CKS0;
      sar_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      tick_reg <= tick_next;
      div_cnt_reg <= div_cnt_next;
      div_lim_reg <= div_lim_next;
      sar_reg <= sar_next;
    end
  end

  // Result holds no reset value
  always_comb begin
    result_next = done ? sar_next : result_reg;
  end

  always_ff @(posedge i_ref_clk) begin
    result_reg <= result_next;
  end

  // Read data and pin controls
  always_comb begin
    rdata_next = adc_seq_pkg::RDATA_RST;
    if (i_rd) begin
      if (i_addr == adc_seq_pkg::CTRL_OFS) begin
        rdata_next = {en_reg, start_reg, eoc_reg, gch_reg, 1'b0, chs_reg};
      end else if (i_addr == adc_seq_pkg::RES_HI_OFS) begin
        rdata_next = result_reg[11:4];
      end else if (i_addr == adc_seq_pkg::CKS_LO_OFS) begin
        rdata_next = {1'b0, cks_reg[1], 1'b0, cks_reg[0], result_reg[3:0]};
      end else if (i_addr == adc_seq_pkg::PIN_CFG_OFS) begin
        rdata_next = {3'h0, pin_cfg_reg};
      end else begin
        rdata_next = adc_seq_pkg::RDATA_RST;
      end
    end
    // Pin direction and pull-up are never touched here
    conn_next = channel_onehot(en_next, gch_next, chs_next);
    sample_next = (state_next == adc_seq_pkg::ST_SAMPLE);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= adc_seq_pkg::RDATA_RST;
      conn_reg <= 5'h00;
      sample_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      conn_reg <= conn_next;
      sample_reg <= sample_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_converter_power = en_reg;
  assign o_channel_connect = conn_reg;
  assign o_pin_analog_only = pin_cfg_reg;
  assign o_sample = sample_reg;
  assign o_trial_code = sar_reg;

  // Cycle count since conversion entry, and a flag once a result is known
  logic [10:0] cyc_reg, cyc_next;
  logic res_valid_reg, res_valid_next;
  always_comb begin
    cyc_next = start_ok ? 11'h000 : (busy ? cyc_reg + 11'h001 : cyc_reg);
    res_valid_next = res_valid_reg || done;
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc_reg <= 11'h000;
      res_valid_reg <= 1'b0;
    end else begin
      cyc_reg <= cyc_next;
      res_valid_reg <= res_valid_next;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  start_ignored_a: assert property (
    (i_wr && i_addr == adc_seq_pkg::CTRL_OFS && !busy
     && !(i_wdata[7] && i_wdata[4])) |=> (!start_reg && !busy
     && eoc_reg == ($past(i_wdata[6]) ? $past(eoc_reg) : $past(i_wdata[5]))))
    else $error("start taken without enables");
  start_accept_a: assert property (
    start_ok |=> (start_reg && !eoc_reg && o_sample && state_reg == adc_seq_pkg::ST_SAMPLE))
    else $error("accepted start did not begin conversion");
  eoc_busy_a: assert property (busy |-> !eoc_reg)
    else $error("end flag high during conversion");
  done_flag_a: assert property (
    done |=> (eoc_reg && !start_reg && !busy && result_reg == $past(sar_next)))
    else $error("completion did not post result");
  conv_length_a: assert property (
    done |-> (cyc_reg == 11'({6'h00, div_lim_reg} * adc_seq_pkg::TICKS_PER_CONV - 11'h001)))
    else $error("conversion length wrong");
  mux_onehot_a: assert property ($onehot0(o_channel_connect))
    else $error("more than one pin connected");
  mux_select_a: assert property (
    (en_reg && gch_reg && chs_reg < 3'h5) |-> o_channel_connect[chs_reg])
    else $error("selected channel not connected");
  mux_off_a: assert property (!(en_reg && gch_reg) |-> o_channel_connect == 5'h00)
    else $error("channel connected while disabled");
  low_write_a: assert property ((wr_lo && !done && res_valid_reg) |=> $stable(result_reg))
    else $error("low register write changed result");
  read_high_a: assert property (
    (i_rd && i_addr == adc_seq_pkg::RES_HI_OFS) |=> (o_rdata == $past(result_reg[11:4])) ##1
    (o_rdata == 8'h00 || $past(i_rd)))
    else $error("high byte read wrong");
  cks_sel_a: assert property (
    start_ok |=> div_lim_reg == div_limit($past(cks_reg)))
    else $error("divider not taken from clock select");

  // Register port checks
  rdata_idle_a: assert property (!i_rd |=> (o_rdata == 8'h00))
    else $error("read data not cleared");
  read_ctrl_a: assert property (
    (i_rd && i_addr == adc_seq_pkg::CTRL_OFS) |=> (!o_rdata[3]
    && o_rdata[adc_seq_pkg::CTRL_EN_BIT] == $past(en_reg)
    && o_rdata[adc_seq_pkg::CTRL_START_BIT] == $past(start_reg)
    && o_rdata[adc_seq_pkg::CTRL_EOC_BIT] == $past(eoc_reg)))
    else $error("control read wrong");
  read_low_a: assert property (
    (i_rd && i_addr == adc_seq_pkg::CKS_LO_OFS && res_valid_reg)
    |=> (o_rdata[3:0] == $past(result_reg[3:0]) && !o_rdata[7] && !o_rdata[5]
    && o_rdata[adc_seq_pkg::CKS1_BIT] == $past(cks_reg[1])
    && o_rdata[adc_seq_pkg::CKS0_BIT] == $past(cks_reg[0])))
    else $error("low register read wrong");
  pin_cfg_a: assert property (
    wr_pin |=> (o_pin_analog_only == $past(i_wdata[4:0])))
    else $error("pin config not taken");
  power_follow_a: assert property (
    wr_ctrl |=> (o_converter_power == $past(i_wdata[adc_seq_pkg::CTRL_EN_BIT])))
    else $error("power bit not followed");

  // Sequencer checks
  abort_idle_a: assert property (
    abort |=> (!busy && !start_reg && !eoc_reg && !o_sample
    && (!res_valid_reg || $stable(result_reg))))
    else $error("abort did not stop conversion");
  busy_hold_a: assert property (
    (busy && wr_ctrl && !abort && !done) |=> (busy && start_reg
    && cyc_reg == $past(cyc_reg) + 11'h001))
    else $error("start while busy restarted conversion");
  step_advance_a: assert property (
    (step_end && !abort && !done) |=> (step_reg == $past(step_reg) + 4'h1))
    else $error("step counter did not advance");
  div_count_a: assert property (busy |-> (div_cnt_reg < div_lim_reg))
    else $error("divider count out of range");
  lim_stable_a: assert property ((busy && !abort) |=> $stable(div_lim_reg))
    else $error("divider changed mid-conversion");
  sample_span_a: assert property (
    o_sample |-> (state_reg == adc_seq_pkg::ST_SAMPLE
    && step_reg <= adc_seq_pkg::SAMPLE_LAST_STEP))
    else $error("sample outside sample steps");
  sar_first_a: assert property (
    (state_reg == adc_seq_pkg::ST_SAMPLE && step_end && !abort
     && step_reg == adc_seq_pkg::SAMPLE_LAST_STEP) |=> (!o_sample
     && o_trial_code == adc_seq_pkg::SAR_FIRST_TRIAL))
    else $error("first trial code wrong");
  trial_bit_a: assert property (
    (state_reg == adc_seq_pkg::ST_RESOLVE && step_end && !abort
     && step_reg != adc_seq_pkg::LAST_STEP)
    |=> (o_trial_code[$past(bidx)] == $past(i_cmp_above)
    && o_trial_code[$past(bidx) - 4'h1]))
    else $error("trial bit not decided");

  conv_done_c: cover property (done);
  conv_fast_c: cover property (done && div_lim_reg == adc_seq_pkg::DIV_CKS2);
  conv_abort_c: cover property (abort);
  ignored_start_c: cover property (wr_ctrl && i_wdata[6] && !i_wdata[7] && !busy);
  start_hit_c: cover property (start_ok);

endmodule // adc_sequencer_control
`default_nettype wire

// ### analog_input_model.sv
// Purpose: Analog input and comparator stand-in for the converter sequencer
// Assumes: One test level sits on whichever channel is connected
// Notes: Unpowered or unconnected, the answer toggles every cycle
`timescale 1ns/100ps
`default_nettype none
module analog_input_model (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [11:0] i_level,
  input wire logic i_power,
  input wire logic [4:0] i_connect,
  input wire logic [11:0] i_trial,
  output logic o_cmp_above
);
  logic flip_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flip_reg <= 1'b0;
    end else begin
      flip_reg <= ~flip_reg;
    end
  end
  // Straight binary compare, only for a single connected channel
  always_comb begin
    if (i_power && ($countones(i_connect) == 1)) begin
      o_cmp_above = (i_level >= i_trial);
    end else begin
      o_cmp_above = flip_reg;
    end
  end
endmodule // analog_input_model
`default_nettype wire

// ### adc_sequencer_control_test.sv
// Purpose: Self-checking bench for the converter sequencer control block
// Assumes: Register port with read data one cycle after the strobe
// Notes: Random values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control_test;
  logic clk, nrst, wr, rd, cmp, power, smp;
  logic [7:0] addr, wdata, rdata, v, w;
  logic [4:0] conn, pin_cfg;
  logic [11:0] trial, level;
  int err_total, n_checks, smp_len, smp_run;
  // Converter settle time after power-up, 100 us
  localparam int SETTLE_CYC = 2000;

  adc_sequencer_control dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_cmp_above(cmp), .o_rdata(rdata),
    .o_converter_power(power), .o_channel_connect(conn), .o_pin_analog_only(pin_cfg),
    .o_sample(smp), .o_trial_code(trial));
  analog_input_model model_u (.i_ref_clk(clk), .i_nrst(nrst), .i_level(level),
    .i_power(power), .i_connect(conn), .i_trial(trial), .o_cmp_above(cmp));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Length of the last sample burst
  always @(negedge clk) begin
    if (smp === 1'b1) begin
      smp_run = smp_run + 1;
    end else if (smp_run != 0) begin
      smp_len = smp_run;
      smp_run = 0;
    end
  end

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [4:0] exp_conn(logic en, logic gch, logic [2:0] chs);
    return (en && gch && chs < 3'h5) ? (5'h01 << chs) : 5'h00;
  endfunction

  task automatic convert(input logic [1:0] cks, input logic [2:0] ch, input logic [11:0] lvl);
    int div, n;
    div = (cks == 2'h0) ? 16 : (cks == 2'h1) ? 8 : (cks == 2'h2) ? 1 : 2;
    level = lvl;
    if (power !== 1'b1) begin
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h90 | {5'h00, ch});
      repeat (SETTLE_CYC) @(posedge clk);
    end
    wr_reg(adc_seq_pkg::CKS_LO_OFS, {1'b0, cks[1], 1'b0, cks[0], 4'h0});
    wr_reg(adc_seq_pkg::CTRL_OFS, 8'hD0 | {5'h00, ch});
    @(posedge clk);
    rd <= 1'b1; addr <= adc_seq_pkg::CTRL_OFS;
    n = 0;
    do begin
      @(posedge clk);
      #1 v = rdata;
      if (n == 0) chk("busy ctrl", v, 8'hD0 | {5'h00, ch});
      if (n == 0) chk("connect", conn, exp_conn(1'b1, 1'b1, ch));
      n++;
    end while (v[5] !== 1'b1 && n < 1100);
    @(posedge clk);
    rd <= 1'b0;
    if (v[5] !== 1'b1) begin
      chk("eoc timeout", 12'h000, 12'h001);
      conclude();
    end
    chk("conv cycles", n[11:0], 12'(64 * div));
    chk("sample len", smp_len[11:0], 12'(16 * div));
    chk("done ctrl", v, 8'hB0 | {5'h00, ch});
    rd_reg(adc_seq_pkg::RES_HI_OFS, v);
    chk("result hi", v, lvl[11:4]);
    rd_reg(adc_seq_pkg::CKS_LO_OFS, v);
    chk("result lo", v, {1'b0, cks[1], 1'b0, cks[0], lvl[3:0]});
    wr_reg(adc_seq_pkg::RES_HI_OFS, ~lvl[11:4]);
    wr_reg(adc_seq_pkg::CKS_LO_OFS, ~{1'b0, cks[1], 1'b0, cks[0], lvl[3:0]});
    rd_reg(adc_seq_pkg::RES_HI_OFS, v);
    chk("hi readonly", v, lvl[11:4]);
    rd_reg(adc_seq_pkg::CKS_LO_OFS, v);
    chk("lo write", v, {1'b0, ~cks[1], 1'b0, ~cks[0], lvl[3:0]});
  endtask

  initial begin
    logic [7:0] refused [3];
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00; level = 12'h000;
    err_total = 0; n_checks = 0; smp_len = 0; smp_run = 0;
    refused = '{8'h60, 8'hC0, 8'h50};
    v = 8'($urandom(68));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(adc_seq_pkg::CTRL_OFS, v);
    chk("ctrl reset", v, 8'h00);
    rd_reg(adc_seq_pkg::PIN_CFG_OFS, v);
    chk("pin reset", v, 8'h00);
    rd_reg(adc_seq_pkg::CKS_LO_OFS, v);
    chk("cks reset", v & 8'hF0, 8'h00);
    rd_reg(8'hB4, v);
    chk("unmapped", v, 8'h00);
    $display("Test reset done");
    for (int i = 0; i < 8; i++) begin
      w = 8'($urandom);
      wr_reg(adc_seq_pkg::CTRL_OFS, {w[7], 1'b0, w[5:3], 3'(i)});
      rd_reg(adc_seq_pkg::CTRL_OFS, v);
      chk("ctrl rw", v, {w[7], 1'b0, w[5:4], 1'b0, 3'(i)});
      chk("power", power, w[7]);
      chk("channels", conn, exp_conn(w[7], w[4], 3'(i)));
      wr_reg(adc_seq_pkg::PIN_CFG_OFS, w);
      rd_reg(adc_seq_pkg::PIN_CFG_OFS, v);
      chk("pin rw", v, {3'h0, w[4:0]});
      chk("pin iso", pin_cfg, w[4:0]);
    end
    $display("Test config done");
    for (int i = 0; i < 3; i++) begin
      wr_reg(adc_seq_pkg::CTRL_OFS, refused[i]);
      rd_reg(adc_seq_pkg::CTRL_OFS, v);
      chk("refused", v, (refused[i] & 8'h97) | (w & 8'h20));
      chk("no sample", smp, 1'b0);
    end
    $display("Test refused done");
    for (int i = 0; i < 6; i++) begin
      convert(2'(i), 3'($urandom % 5), (i == 4) ? 12'h000 : (i == 5) ? 12'hFFF : 12'($urandom));
    end
    $display("Test conversion done");
    wr_reg(adc_seq_pkg::CKS_LO_OFS, 8'h00);
    wr_reg(adc_seq_pkg::CTRL_OFS, 8'hD2);
    wr_reg(adc_seq_pkg::CTRL_OFS, 8'hD2);
    rd_reg(adc_seq_pkg::CTRL_OFS, v);
    chk("restart busy", v, 8'hD2);
    chk("abort sample", smp, 1'b1);
    wr_reg(adc_seq_pkg::CTRL_OFS, 8'h92);
    rd_reg(adc_seq_pkg::CTRL_OFS, v);
    chk("abort ctrl", v, 8'h92);
    chk("abort idle", smp, 1'b0);
    repeat (1100) @(posedge clk);
    rd_reg(adc_seq_pkg::RES_HI_OFS, v);
    chk("abort hold", v, 8'hFF);
    rd_reg(adc_seq_pkg::CTRL_OFS, v);
    chk("abort stays", v, 8'h92);
    $display("Test abort done");
    wr_reg(adc_seq_pkg::CTRL_OFS, 8'h00);
    rd_reg(adc_seq_pkg::CTRL_OFS, v);
    chk("sleep ctrl", v, 8'h00);
    chk("sleep power", power, 1'b0);
    chk("sleep conn", conn, 5'h00);
    $display("Test sleep done");
    conclude();
  end
endmodule // adc_sequencer_control_test
`default_nettype wire
